// >>> include/sdbc_consts.vh
`ifndef SDBC_CONSTS_VH
`define SDBC_CONSTS_VH
`define SDBC_OFS_SPEED_DETECT 8'h80
`define SDBC_OFS_REVERSAL     8'h82
`define SDBC_RESET_VALUE      32'h00000000
`define SDBC_CODE_RESERVED    16'hffff
`define SDBC_BIT_DETECT_EN    30
`define SDBC_BIT_BRAKE_EN     29
`define SDBC_BIT_COAST_EN     28
`define SDBC_BIT_REVERSAL_EN  27
`define SDBC_BIT_RESYNCHRONIZATION_ENABLE    26
`define SDBC_RESYNC_MSB       25
`define SDBC_RESYNC_LSB       22
`define SDBC_BIT_FET_SIDE     21
`define SDBC_BIT_EXIT_COND    20
`define SDBC_BRK_CUR_MSB      19
`define SDBC_BRK_CUR_LSB      17
`define SDBC_BRAKING_DURATION_MSB     16
`define SDBC_BRAKING_DURATION_LSB     13
`define SDBC_COAST_MSB        12
`define SDBC_COAST_LSB        9
`define SDBC_STILL_MSB        8
`define SDBC_STILL_LSB        6
`define SDBC_HANDOFF_MSB      5
`define SDBC_HANDOFF_LSB      2
`define SDBC_OL_CUR_MSB       1
`define SDBC_OL_CUR_LSB       0
`define SDBC_A1_MSB           30
`define SDBC_A1_LSB           27
`define SDBC_A2_MSB           26
`define SDBC_A2_LSB           23
`define SDBC_AB_CUR_MSB       22
`define SDBC_AB_CUR_LSB       20
`define SDBC_KP_MSB           19
`define SDBC_KP_LSB           10
`define SDBC_KI_MSB           9
`define SDBC_KI_LSB           0
`define SDBC_KP_FRAC_BITS     7
`define SDBC_KI_FRAC_BITS     9
`endif

// >>> design/sdbc_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "sdbc_consts.vh"
// decoded outputs are fixed-point physical values:
// percent x10, amps x10000, ms, mV, Hz/s x100, gains as Q-format raw codes
module sdbc_regs (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RST_B,
  // register access from the serial interface, same clock
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_ADDR,
  input  wire [31:0] REG_WDATA,
  output reg  [31:0] REG_RDATA,
  output reg         REG_RVALID,
  output reg         REG_ERR,
  // enables
  output reg         SPEED_DETECTION_ENABLE,
  output reg         BRAKING_ENABLE,
  output reg         COAST_ENABLE,
  output reg         REVERSAL_ENABLE,
  output reg         RESYNCHRONIZATION_ENABLE,
  // braking control
  output reg         BRAKE_HIGH_SIDES_ON,
  output reg         BRAKE_LOW_SIDES_ON,
  output reg         BRAKE_EXIT_USES_CURRENT,
  // decoded settings
  output reg  [9:0]  RESYNC_SPEED_PCT_X10,
  output reg  [15:0] BRAKE_EXIT_CURRENT_X10K,
  output reg  [15:0] BRAKE_DURATION_MS,
  output reg  [15:0] COAST_DURATION_MS,
  output reg  [10:0] STANDSTILL_BEMF_MV,
  output reg  [9:0]  HANDOFF_SPEED_PCT_X10,
  output reg  [15:0] OPENLOOP_CURRENT_X10K,
  output reg  [19:0] LINEAR_ACCEL_X100,
  output reg         LINEAR_ACCEL_INVALID,
  output reg  [19:0] QUAD_ACCEL_X100,
  output reg  [15:0] REGEN_CURRENT_X10K,
  output reg         REGEN_CURRENT_INVALID,
  output reg  [9:0]  REGEN_PROP_GAIN_Q7,
  output reg  [9:0]  REGEN_INTEGRAL_GAIN_Q9
);

  reg  [31:0] detect_reg;
  reg  [31:0] reversal_reg;
  wire        hit_detect   = (REG_ADDR == `SDBC_OFS_SPEED_DETECT);
  wire        hit_reversal = (REG_ADDR == `SDBC_OFS_REVERSAL);

  // register storage; reserved bit 31 is kept but drives nothing
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      detect_reg   <= `SDBC_RESET_VALUE;
      reversal_reg <= `SDBC_RESET_VALUE;
    end else if (REG_WR) begin
      if (hit_detect)
        detect_reg <= REG_WDATA;
      if (hit_reversal)
        reversal_reg <= REG_WDATA;
    end
  end

  // read port; unmapped offsets return zero and flag an error
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA  <= 32'h00000000;
      REG_RVALID <= 1'b0;
      REG_ERR    <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      REG_ERR    <= (REG_RD | REG_WR) & ~(hit_detect | hit_reversal);
      if (REG_RD)
        REG_RDATA <= hit_detect ? detect_reg : (hit_reversal ? reversal_reg : 32'h00000000);
    end
  end

  // field extraction
  wire [3:0] f_resync  = detect_reg[`SDBC_RESYNC_MSB:`SDBC_RESYNC_LSB];
  wire [2:0] f_brkcur  = detect_reg[`SDBC_BRK_CUR_MSB:`SDBC_BRK_CUR_LSB];
  wire [3:0] f_brktime = detect_reg[`SDBC_BRAKING_DURATION_MSB:`SDBC_BRAKING_DURATION_LSB];
  wire [3:0] f_coast   = detect_reg[`SDBC_COAST_MSB:`SDBC_COAST_LSB];
  wire [2:0] f_still   = detect_reg[`SDBC_STILL_MSB:`SDBC_STILL_LSB];
  wire [3:0] f_handoff = detect_reg[`SDBC_HANDOFF_MSB:`SDBC_HANDOFF_LSB];
  wire [1:0] f_olcur   = detect_reg[`SDBC_OL_CUR_MSB:`SDBC_OL_CUR_LSB];
  wire [3:0] f_a1      = reversal_reg[`SDBC_A1_MSB:`SDBC_A1_LSB];
  wire [3:0] f_a2      = reversal_reg[`SDBC_A2_MSB:`SDBC_A2_LSB];
  wire [2:0] f_abcur   = reversal_reg[`SDBC_AB_CUR_MSB:`SDBC_AB_CUR_LSB];

  reg [9:0]  resync_next;
  reg [15:0] brkcur_next;
  reg [15:0] duration_next;
  reg [15:0] coast_next;
  reg [10:0] still_next;
  reg [9:0]  handoff_next;
  reg [15:0] olcur_next;
  reg [19:0] a1_next;
  reg [19:0] a2_next;
  reg [15:0] abcur_next;

  // 16-entry duration table, shared shape for brake and coast
  function [15:0] sdbc_duration_ms;
    input [3:0] code;
    begin
      case (code)
        4'h0: sdbc_duration_ms = 16'd10;
        4'h1: sdbc_duration_ms = 16'd50;
        4'h2: sdbc_duration_ms = 16'd100;
        4'h3: sdbc_duration_ms = 16'd200;
        4'h4: sdbc_duration_ms = 16'd300;
        4'h5: sdbc_duration_ms = 16'd400;
        4'h6: sdbc_duration_ms = 16'd500;
        4'h7: sdbc_duration_ms = 16'd750;
        4'h8: sdbc_duration_ms = 16'd1000;
        4'h9: sdbc_duration_ms = 16'd2000;
        4'ha: sdbc_duration_ms = 16'd3000;
        4'hb: sdbc_duration_ms = 16'd4000;
        4'hc: sdbc_duration_ms = 16'd5000;
        4'hd: sdbc_duration_ms = 16'd7500;
        4'he: sdbc_duration_ms = 16'd10000;
        default: sdbc_duration_ms = 16'd15000;
      endcase
    end
  endfunction

  // accel table shared by both coefficients except code 0 and e
  function [19:0] sdbc_accel_x100;
    input [3:0] code;
    begin
      case (code)
        4'h0: sdbc_accel_x100 = 20'd1;
        4'h1: sdbc_accel_x100 = 20'd5;
        4'h2: sdbc_accel_x100 = 20'd100;
        4'h3: sdbc_accel_x100 = 20'd250;
        4'h4: sdbc_accel_x100 = 20'd500;
        4'h5: sdbc_accel_x100 = 20'd1000;
        4'h6: sdbc_accel_x100 = 20'd2500;
        4'h7: sdbc_accel_x100 = 20'd5000;
        4'h8: sdbc_accel_x100 = 20'd7500;
        4'h9: sdbc_accel_x100 = 20'd10000;
        4'ha: sdbc_accel_x100 = 20'd25000;
        4'hb: sdbc_accel_x100 = 20'd50000;
        4'hc: sdbc_accel_x100 = 20'd75000;
        4'hd: sdbc_accel_x100 = 20'd100000;
        4'he: sdbc_accel_x100 = 20'd500000;
        default: sdbc_accel_x100 = 20'd1000000;
      endcase
    end
  endfunction

  always @* begin
    // 5% steps up to 60%, then 10% steps
    if (f_resync <= 4'hb)
      resync_next = {6'h00, f_resync} * 10'd50 + 10'd50;
    else
      resync_next = {6'h00, f_resync} * 10'd100 - 10'd500;
    case (f_brkcur)
      3'h0: brkcur_next = 16'd625;
      3'h1: brkcur_next = 16'd1250;
      3'h2: brkcur_next = 16'd1875;
      3'h3: brkcur_next = 16'd3125;
      3'h4: brkcur_next = 16'd6250;
      3'h5: brkcur_next = 16'd12500;
      3'h6: brkcur_next = 16'd25000;
      default: brkcur_next = 16'd50000;
    endcase
    duration_next = sdbc_duration_ms(f_brktime);
    coast_next    = sdbc_duration_ms(f_coast);
    case (f_still)
      3'h0: still_next = 11'd50;
      3'h1: still_next = 11'd75;
      3'h2: still_next = 11'd100;
      3'h3: still_next = 11'd250;
      3'h4: still_next = 11'd500;
      3'h5: still_next = 11'd750;
      3'h6: still_next = 11'd1000;
      default: still_next = 11'd1500;
    endcase
    case (f_handoff)
      4'h0: handoff_next = 10'd25;
      4'h1: handoff_next = 10'd50;
      4'h2: handoff_next = 10'd75;
      4'h3: handoff_next = 10'd100;
      4'h4: handoff_next = 10'd125;
      4'h5: handoff_next = 10'd150;
      4'h6: handoff_next = 10'd200;
      4'h7: handoff_next = 10'd250;
      4'h8: handoff_next = 10'd300;
      4'h9: handoff_next = 10'd400;
      4'ha: handoff_next = 10'd500;
      4'hb: handoff_next = 10'd600;
      4'hc: handoff_next = 10'd700;
      4'hd: handoff_next = 10'd800;
      4'he: handoff_next = 10'd900;
      default: handoff_next = 10'd1000;
    endcase
    case (f_olcur)
      2'h0: olcur_next = 16'd9375;
      2'h1: olcur_next = 16'd15625;
      2'h2: olcur_next = 16'd21875;
      default: olcur_next = 16'd31250;
    endcase
    // code e has no linear value; report zero and flag it
    a1_next = (f_a1 == 4'he) ? 20'd0 : sdbc_accel_x100(f_a1);
    a2_next = (f_a2 == 4'h0) ? 20'd0 : sdbc_accel_x100(f_a2);
    case (f_abcur)
      3'h0: abcur_next = 16'd3125;
      3'h1: abcur_next = 16'd6250;
      3'h2: abcur_next = 16'd12500;
      3'h3: abcur_next = 16'd18750;
      3'h4: abcur_next = 16'd25000;
      3'h5: abcur_next = 16'd31250;
      3'h6: abcur_next = 16'd37500;
      default: abcur_next = 16'd0;
    endcase
  end

  // outputs registered so the control loop never sees a decode glitch
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SPEED_DETECTION_ENABLE   <= 1'b0;
      BRAKING_ENABLE           <= 1'b0;
      COAST_ENABLE             <= 1'b0;
      REVERSAL_ENABLE          <= 1'b0;
      RESYNCHRONIZATION_ENABLE <= 1'b0;
      BRAKE_HIGH_SIDES_ON      <= 1'b0;
      BRAKE_LOW_SIDES_ON       <= 1'b0;
      BRAKE_EXIT_USES_CURRENT  <= 1'b0;
      RESYNC_SPEED_PCT_X10     <= 10'h000;
      BRAKE_EXIT_CURRENT_X10K  <= 16'h0000;
      BRAKE_DURATION_MS        <= 16'h0000;
      COAST_DURATION_MS        <= 16'h0000;
      STANDSTILL_BEMF_MV       <= 11'h000;
      HANDOFF_SPEED_PCT_X10    <= 10'h000;
      OPENLOOP_CURRENT_X10K    <= 16'h0000;
      LINEAR_ACCEL_X100        <= 20'h00000;
      LINEAR_ACCEL_INVALID     <= 1'b0;
      QUAD_ACCEL_X100          <= 20'h00000;
      REGEN_CURRENT_X10K       <= 16'h0000;
      REGEN_CURRENT_INVALID    <= 1'b0;
      REGEN_PROP_GAIN_Q7       <= 10'h000;
      REGEN_INTEGRAL_GAIN_Q9   <= 10'h000;
    end else begin
      SPEED_DETECTION_ENABLE   <= detect_reg[`SDBC_BIT_DETECT_EN];
      BRAKING_ENABLE           <= detect_reg[`SDBC_BIT_BRAKE_EN];
      COAST_ENABLE             <= detect_reg[`SDBC_BIT_COAST_EN];
      REVERSAL_ENABLE          <= detect_reg[`SDBC_BIT_REVERSAL_EN];
      RESYNCHRONIZATION_ENABLE <= detect_reg[`SDBC_BIT_RESYNCHRONIZATION_ENABLE];
      // sides only asserted while braking is enabled, never both
      BRAKE_HIGH_SIDES_ON <= detect_reg[`SDBC_BIT_BRAKE_EN] & ~detect_reg[`SDBC_BIT_FET_SIDE];
      BRAKE_LOW_SIDES_ON  <= detect_reg[`SDBC_BIT_BRAKE_EN] & detect_reg[`SDBC_BIT_FET_SIDE];
      BRAKE_EXIT_USES_CURRENT  <= detect_reg[`SDBC_BIT_EXIT_COND];
      RESYNC_SPEED_PCT_X10     <= resync_next;
      BRAKE_EXIT_CURRENT_X10K  <= brkcur_next;
      BRAKE_DURATION_MS        <= duration_next;
      COAST_DURATION_MS        <= coast_next;
      STANDSTILL_BEMF_MV       <= still_next;
      HANDOFF_SPEED_PCT_X10    <= handoff_next;
      OPENLOOP_CURRENT_X10K    <= olcur_next;
      LINEAR_ACCEL_X100        <= a1_next;
      LINEAR_ACCEL_INVALID     <= (f_a1 == 4'he);
      QUAD_ACCEL_X100          <= a2_next;
      REGEN_CURRENT_X10K       <= abcur_next;
      REGEN_CURRENT_INVALID    <= (f_abcur == 3'h7);
      REGEN_PROP_GAIN_Q7       <= reversal_reg[`SDBC_KP_MSB:`SDBC_KP_LSB];
      REGEN_INTEGRAL_GAIN_Q9   <= reversal_reg[`SDBC_KI_MSB:`SDBC_KI_LSB];
    end
  end

endmodule // sdbc_regs
`default_nettype wire

// >>> testbench/sdbc_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sdbc_chk (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST_B,
  // register bus
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_RVALID,
  input wire logic        REG_ERR,
  // decoded outputs
  input wire logic        SPEED_DETECTION_ENABLE,
  input wire logic        BRAKE_HIGH_SIDES_ON,
  input wire logic        BRAKE_LOW_SIDES_ON,
  input wire logic        BRAKE_EXIT_USES_CURRENT,
  input wire logic        REGEN_CURRENT_INVALID,
  input wire logic [9:0]  REGEN_PROP_GAIN_Q7,
  input wire logic [9:0]  REGEN_INTEGRAL_GAIN_Q9
);
  wire logic wr_det = REG_WR && REG_ADDR == 8'h80;
  wire logic wr_rev = REG_WR && REG_ADDR == 8'h82;
  wire logic bad    = REG_ADDR != 8'h80 && REG_ADDR != 8'h82;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  read_answered_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered");
  err_decode_a: assert property ((REG_RD || REG_WR) |=> REG_ERR == $past(bad))
    else $error("error flag wrong");
  fet_high_a: assert property (wr_det |-> ##2
    BRAKE_HIGH_SIDES_ON == ($past(REG_WDATA[29], 2) & ~$past(REG_WDATA[21], 2)))
    else $error("high side select wrong");
  fet_low_a: assert property (wr_det |-> ##2
    BRAKE_LOW_SIDES_ON == ($past(REG_WDATA[29], 2) & $past(REG_WDATA[21], 2)))
    else $error("low side select wrong");
  fet_excl_a: assert property (!(BRAKE_HIGH_SIDES_ON && BRAKE_LOW_SIDES_ON))
    else $error("both sides on");
  exit_cond_a: assert property (wr_det |-> ##2
    BRAKE_EXIT_USES_CURRENT == $past(REG_WDATA[20], 2)) else $error("exit select wrong");
  detect_en_a: assert property (wr_det |-> ##2
    SPEED_DETECTION_ENABLE == $past(REG_WDATA[30], 2)) else $error("enable wrong");
  prop_gain_a: assert property (wr_rev |-> ##2
    REGEN_PROP_GAIN_Q7 == $past(REG_WDATA[19:10], 2)) else $error("kp wrong");
  int_gain_a: assert property (wr_rev |-> ##2
    REGEN_INTEGRAL_GAIN_Q9 == $past(REG_WDATA[9:0], 2)) else $error("ki wrong");
  regen_resv_a: assert property (wr_rev |-> ##2
    REGEN_CURRENT_INVALID == ($past(REG_WDATA[22:20], 2) == 3'h7)) else $error("code 7 flag");
endmodule // sdbc_chk
bind sdbc_regs sdbc_chk sdbc_chk_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID),
  .REG_ERR(REG_ERR), .SPEED_DETECTION_ENABLE(SPEED_DETECTION_ENABLE),
  .BRAKE_HIGH_SIDES_ON(BRAKE_HIGH_SIDES_ON), .BRAKE_LOW_SIDES_ON(BRAKE_LOW_SIDES_ON),
  .BRAKE_EXIT_USES_CURRENT(BRAKE_EXIT_USES_CURRENT),
  .REGEN_CURRENT_INVALID(REGEN_CURRENT_INVALID), .REGEN_PROP_GAIN_Q7(REGEN_PROP_GAIN_Q7),
  .REGEN_INTEGRAL_GAIN_Q9(REGEN_INTEGRAL_GAIN_Q9));
`default_nettype wire

// >>> testbench/sdbc_host.sv
`timescale 1ns/10ps
`default_nettype none
module sdbc_host (
  // clock
  input wire logic         SYS_CLK,
  // answers
  input wire logic  [31:0] REG_RDATA,
  input wire logic         REG_RVALID,
  input wire logic         REG_ERR,
  // requests
  output var logic         REG_WR,
  output var logic         REG_RD,
  output var logic  [7:0]  REG_ADDR,
  output var logic  [31:0] REG_WDATA
);
  initial begin
    REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h00; REG_WDATA = 32'h00000000;
  end
  // released lines show inverted data so a stale sample cannot pass
  task wr(input logic [7:0] a, input logic [31:0] d, output logic e);
    @(posedge SYS_CLK); REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
    @(posedge SYS_CLK); REG_WR <= 1'b0; REG_ADDR <= ~a; REG_WDATA <= ~d;
    @(negedge SYS_CLK); e = REG_ERR;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic e, output logic got);
    got = 1'b0; d = 32'h00000000; e = 1'b0;
    @(posedge SYS_CLK); REG_RD <= 1'b1; REG_ADDR <= a;
    @(posedge SYS_CLK); REG_RD <= 1'b0; REG_ADDR <= ~a;
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge SYS_CLK);
      if (REG_RVALID === 1'b1) begin
        got = 1'b1; d = REG_RDATA; e = REG_ERR;
      end
    end
  endtask
endmodule // sdbc_host
`default_nettype wire

// >>> testbench/sdbc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sdbc_regs_tb;
  logic SYS_CLK, RST_B, REG_WR, REG_RD, REG_RVALID, REG_ERR, got, e;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, d, w;
  logic SPEED_DETECTION_ENABLE, BRAKING_ENABLE, COAST_ENABLE, REVERSAL_ENABLE;
  logic RESYNCHRONIZATION_ENABLE, BRAKE_HIGH_SIDES_ON, BRAKE_LOW_SIDES_ON;
  logic BRAKE_EXIT_USES_CURRENT, LINEAR_ACCEL_INVALID, REGEN_CURRENT_INVALID;
  logic [9:0] RESYNC_SPEED_PCT_X10, HANDOFF_SPEED_PCT_X10, REGEN_PROP_GAIN_Q7;
  logic [9:0] REGEN_INTEGRAL_GAIN_Q9;
  logic [15:0] BRAKE_EXIT_CURRENT_X10K, BRAKE_DURATION_MS, COAST_DURATION_MS;
  logic [15:0] OPENLOOP_CURRENT_X10K, REGEN_CURRENT_X10K;
  logic [10:0] STANDSTILL_BEMF_MV;
  logic [19:0] LINEAR_ACCEL_X100, QUAD_ACCEL_X100;
  int num_errors = 0, n_tests = 0;
  // decoded tables; plain decimals keep the physical figures readable
  logic [15:0] dur_t [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000, 4000,
    5000, 7500, 10000, 15000};
  logic [15:0] hand_t [16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500, 600, 700,
    800, 900, 1000};
  logic [19:0] quad_t [16] = '{0, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 25000,
    50000, 75000, 100000, 500000, 1000000};
  logic [15:0] bcur_t [8] = '{625, 1250, 1875, 3125, 6250, 12500, 25000, 50000};
  logic [10:0] still_t [8] = '{50, 75, 100, 250, 500, 750, 1000, 1500};
  logic [15:0] regen_t [8] = '{3125, 6250, 12500, 18750, 25000, 31250, 37500, 0};
  logic [15:0] ol_t [4] = '{9375, 15625, 21875, 31250};
  sdbc_regs sdbc_regs_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR), .SPEED_DETECTION_ENABLE(SPEED_DETECTION_ENABLE),
    .BRAKING_ENABLE(BRAKING_ENABLE), .COAST_ENABLE(COAST_ENABLE),
    .REVERSAL_ENABLE(REVERSAL_ENABLE), .RESYNCHRONIZATION_ENABLE(RESYNCHRONIZATION_ENABLE),
    .BRAKE_HIGH_SIDES_ON(BRAKE_HIGH_SIDES_ON), .BRAKE_LOW_SIDES_ON(BRAKE_LOW_SIDES_ON),
    .BRAKE_EXIT_USES_CURRENT(BRAKE_EXIT_USES_CURRENT),
    .RESYNC_SPEED_PCT_X10(RESYNC_SPEED_PCT_X10), .BRAKE_EXIT_CURRENT_X10K(BRAKE_EXIT_CURRENT_X10K),
    .BRAKE_DURATION_MS(BRAKE_DURATION_MS), .COAST_DURATION_MS(COAST_DURATION_MS),
    .STANDSTILL_BEMF_MV(STANDSTILL_BEMF_MV), .HANDOFF_SPEED_PCT_X10(HANDOFF_SPEED_PCT_X10),
    .OPENLOOP_CURRENT_X10K(OPENLOOP_CURRENT_X10K), .LINEAR_ACCEL_X100(LINEAR_ACCEL_X100),
    .LINEAR_ACCEL_INVALID(LINEAR_ACCEL_INVALID), .QUAD_ACCEL_X100(QUAD_ACCEL_X100),
    .REGEN_CURRENT_X10K(REGEN_CURRENT_X10K), .REGEN_CURRENT_INVALID(REGEN_CURRENT_INVALID),
    .REGEN_PROP_GAIN_Q7(REGEN_PROP_GAIN_Q7), .REGEN_INTEGRAL_GAIN_Q9(REGEN_INTEGRAL_GAIN_Q9));
  sdbc_host sdbc_host_i (.SYS_CLK(SYS_CLK), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .REG_ERR(REG_ERR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_chk(input logic [7:0] a, input logic [31:0] v, input logic ee);
    sdbc_host_i.wr(a, v, e);
    check(e, ee);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] v, input logic ee);
    sdbc_host_i.rd(a, d, e, got);
    if (got !== 1'b1) begin
      num_errors++;
      print_verdict;
    end
    check(d, v);
    check(e, ee);
  endtask
  // a second call lands after the other tests and must clear both words again
  task t_reset;
    @(posedge SYS_CLK) RST_B <= 1'b0;
    repeat (16) @(posedge SYS_CLK);
    check(RESYNC_SPEED_PCT_X10, 0);
    RST_B <= 1'b1;
    rd_chk(8'h80, 0, 1'b0);
    rd_chk(8'h82, 0, 1'b0);
    check(BRAKE_DURATION_MS, 10);
    check(LINEAR_ACCEL_X100, 1);
  endtask
  task t_detect_word;
    for (int c = 0; c < 16; c++) begin
      w = {c[1], c[3:0], ~c[0], c[3:0], c[0], c[1], c[2:0], c[3:0], c[3:0], c[2:0], c[3:0],
           c[1:0]};
      wr_chk(8'h80, w, 1'b0);
      rd_chk(8'h80, w, 1'b0);
      check(RESYNC_SPEED_PCT_X10, c < 12 ? 50 * (c + 1) : 700 + 100 * (c - 12));
      check(BRAKE_HIGH_SIDES_ON, c[2] & ~c[0]);
      check(BRAKE_LOW_SIDES_ON, c[2] & c[0]);
      check(BRAKE_EXIT_USES_CURRENT, c[1]);
      check(BRAKE_EXIT_CURRENT_X10K, bcur_t[c[2:0]]);
      check(BRAKE_DURATION_MS, dur_t[c]);
      check(COAST_DURATION_MS, dur_t[c]);
      check(STANDSTILL_BEMF_MV, still_t[c[2:0]]);
      check(HANDOFF_SPEED_PCT_X10, hand_t[c]);
      check(OPENLOOP_CURRENT_X10K, ol_t[c[1:0]]);
      check({SPEED_DETECTION_ENABLE, BRAKING_ENABLE, COAST_ENABLE, REVERSAL_ENABLE,
             RESYNCHRONIZATION_ENABLE}, w[30:26]);
    end
  endtask
  task t_reversal_word;
    for (int c = 0; c < 16; c++) begin
      w = {c[0], c[3:0], c[3:0], c[2:0], c[3:0], ~c[3:0], c[1:0], ~c[3:0], c[1:0], c[3:0]};
      wr_chk(8'h82, w, 1'b0);
      rd_chk(8'h82, w, 1'b0);
      check(LINEAR_ACCEL_X100, c == 14 ? 0 : (c == 0 ? 1 : quad_t[c]));
      check(LINEAR_ACCEL_INVALID, c == 14);
      check(QUAD_ACCEL_X100, quad_t[c]);
      check(REGEN_CURRENT_X10K, regen_t[c[2:0]]);
      check(REGEN_CURRENT_INVALID, c[2:0] == 3'h7);
      check(REGEN_PROP_GAIN_Q7, w[19:10]);
      check(REGEN_INTEGRAL_GAIN_Q9, w[9:0]);
    end
  endtask
  // unmapped places answer with the error flag and leave both words alone
  task t_unmapped;
    wr_chk(8'h84, 32'hffffffff, 1'b1);
    wr_chk(8'h81, 32'hffffffff, 1'b1);
    rd_chk(8'h84, 0, 1'b1);
    rd_chk(8'h80, 32'hfbffffff, 1'b0);
    rd_chk(8'h82, 32'hffff0c3f, 1'b0);
  endtask
  initial begin
    RST_B = 1'b0;
    t_reset;
    t_detect_word;
    t_reversal_word;
    t_unmapped;
    t_reset;
    print_verdict;
  end
endmodule // sdbc_regs_tb
`default_nettype wire
